// ===== tre_avs_slave.sv
// Avalon-MM slave front end: one wait state per access.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/1ns
module tre_avs_slave (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    input  wire logic [tre_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [tre_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [tre_pkg::BE_W-1:0]   avs_byteenable_i,
    output logic      [tre_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                           avs_waitrequest_o,
    tre_bus_if.slave                       bus
);
    import tre_pkg::*;

    typedef enum logic {TRE_BUS_IDLE = 1'b0, TRE_BUS_DONE = 1'b1}
        tre_bus_state_type;

    typedef struct packed {
        tre_bus_state_type state;
        logic [DATA_W-1:0] rdata;
    } tre_avs_state_type;

    tre_avs_state_type s_q;
    tre_avs_state_type s_d;

    wire logic req = avs_read_i | avs_write_i;

    // Read data is sampled in the wait cycle so it comes from a flop.
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            TRE_BUS_IDLE: begin
                if (req) begin
                    s_d.state = TRE_BUS_DONE;
                    s_d.rdata = avs_read_i ? bus.rdata : '0;
                end
            end
            TRE_BUS_DONE: s_d.state = TRE_BUS_IDLE;
            default:      s_d.state = TRE_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{state: TRE_BUS_IDLE, rdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest_o = req & (s_q.state != TRE_BUS_DONE);
    assign avs_readdata_o    = s_q.rdata;
    assign bus.wr_stb        = avs_write_i & (s_q.state == TRE_BUS_DONE);
    assign bus.addr          = avs_address_i;
    assign bus.wdata         = avs_writedata_i;
    assign bus.be            = avs_byteenable_i;

endmodule : tre_avs_slave

// ===== tre_bus_if.sv
// Internal register access carrier between the bus slave and the bank.
// Assumes the slave drives strobes and the bank answers with read data.
`timescale 1ns/1ns
interface tre_bus_if;
    import tre_pkg::*;

    logic              wr_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] rdata;

    modport slave (output wr_stb, output addr, output wdata, output be,
                   input rdata);
    modport bank  (input wr_stb, input addr, input wdata, input be,
                   output rdata);
endinterface : tre_bus_if

// ===== tre_inj_check.sv
// Validity check for an error record written through the injection port.
// Purely combinational; assumes the caller merges byte enables first.
`timescale 1ns/1ns
module tre_inj_check (
    input  wire tre_pkg::tre_status_type rec_i,
    output logic                         valid_o
);
    import tre_pkg::*;

    logic ce_legal;

    always_comb begin
        ce_legal = (rec_i.correctable_code == CE_NONE) ||
                   (rec_i.correctable_code == CE_CORRECTED);    // [R6]
        valid_o  = rec_i.record_present &&
                   (rec_i.uncorrected_type == UET_UC) &&
                   ((rec_i.uncorrected_flag && ce_legal) ||
                    (rec_i.postponed_error_flag && ce_legal) ||
                    (rec_i.correctable_code == CE_CORRECTED));  // [R5]
    end

endmodule : tre_inj_check

// ===== tre_pkg.sv
// Package for the translation buffer unit error record register bank.
// Assumes a single clock and reset domain and a 16-bit byte address.
package tre_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_MAIN_TLB_DEPTH_DISC = 16'h8E30;
    localparam logic [ADDR_W-1:0] OFF_ERROR_RECORD_STATUS = 16'h8E90;
    localparam logic [ADDR_W-1:0] OFF_ERROR_INJECTION     = 16'h8EC0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS          = 16'h8F00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK            = 16'h8F04;

    // ------------------------------------------------------------------
    // Field encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  CE_NONE         = 2'h0;
    localparam logic [1:0]  CE_CORRECTED    = 2'h2;
    localparam logic [1:0]  UET_UC          = 2'h0;
    localparam logic [7:0]  CLASS_NONE      = 8'h00;
    localparam logic [7:0]  CLASS_OTHER_RAM = 8'h02;
    localparam logic [7:0]  CLASS_MAIN_TLB_DATA = 8'h08;
    localparam logic [7:0]  CLASS_MAIN_TLB_TAGS = 8'h09;
    localparam logic [31:0] STATUS_IMPL     = 32'h6BB8_FFFF;
    localparam logic [31:0] STATUS_RESET    = 32'h0000_0000;
    localparam logic [31:0] INJ_RESET       = 32'h0000_0000;
    localparam int          DISC_DEPTH_W    = 17;

    // ------------------------------------------------------------------
    // Interrupt status and mask layout
    // ------------------------------------------------------------------
    localparam int         IRQ_W          = 3;
    localparam int         IRQ_RECOVERY   = 0;
    localparam int         IRQ_FAULT      = 1;
    localparam int         IRQ_CRITICAL   = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [2:0] IRQ_STAT_RESET = 3'h0;

    typedef struct packed {
        logic       rsvd31;
        logic       record_present;
        logic       uncorrected_flag;
        logic       rsvd28;
        logic       overflow_flag;
        logic       rsvd26;
        logic [1:0] correctable_code;
        logic       postponed_error_flag;
        logic       rsvd22;
        logic [1:0] uncorrected_type;
        logic       critical_flag;
        logic [2:0] rsvd18_16;
        logic [7:0] source_code_field;
        logic [7:0] error_class_code;
    } tre_status_type;

    function automatic logic [31:0] tre_be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : tre_be_mask

endpackage : tre_pkg

// ===== tre_ras_regs.sv
// Error record register bank of the translation buffer unit.
// Assumes one clock, an Avalon-MM master and error pulses from the datapath.
//
// Behaviour
// [R1] Status bit 19 reports a recorded critical error; software writes ignored.
// [R2] Status bits 15:8 hold the error source code; writes ignored.
// [R3] Status bits 7:0 hold the earliest error class code; writes ignored.
// [R4] A valid injection write copies its value into the status register.
// [R5] Valid needs record present, type 00, and some error condition.
// [R6] Correctable legal as 00 or 10; 10 alone qualifies the record.
// [R7] A valid injected record raises the interrupts a real error would.
// [R8] Injection register at 0x08EC0, read/write, resets to zero.
// [R9] Register 0x08E30 bits 16:0 return main TLB depth; upper read zero.
// [R10] Record-present bit 30 set on error, write-one clears, resets zero.
// [R11] Overflow set on error while record present, or on multiple errors.
// [R12] Invalid injection leaves status and interrupts alone, still stored.
`timescale 1ns/1ns
module tre_ras_regs #(
    parameter int unsigned MAIN_TLB_DEPTH_PARAM = 8
) (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rstn_i,
    input  wire logic [tre_pkg::ADDR_W-1:0] avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [tre_pkg::DATA_W-1:0] avs_writedata_i,
    input  wire logic [tre_pkg::BE_W-1:0]   avs_byteenable_i,
    output logic      [tre_pkg::DATA_W-1:0] avs_readdata_o,
    output logic                            avs_waitrequest_o,
    input  wire logic                       err_valid_i,
    input  wire logic                       err_multi_i,
    input  wire logic                       err_uncorrected_i,
    input  wire logic                       err_postponed_i,
    input  wire logic                       err_corrected_i,
    input  wire logic                       err_critical_i,
    input  wire logic [7:0]                 err_source_i,
    input  wire logic [7:0]                 err_class_i,
    output logic [tre_pkg::IRQ_W-1:0]       irq_status_o,
    output logic                            irq_o
);
    import tre_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] injection;
        tre_status_type    status;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
    } tre_bank_state_type;

    tre_bank_state_type r_q;
    tre_bank_state_type r_d;

    tre_bus_if bus ();

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    tre_avs_slave u_slave (
        .clk_sys_i         (clk_sys_i),
        .rstn_i            (rstn_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .bus               (bus)
    );

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] be_mask;
    logic [DATA_W-1:0] wr_bits;
    logic              wr_status;
    logic              wr_inj;
    logic              wr_irq_stat;
    logic              wr_irq_mask;
    logic [DATA_W-1:0] inj_merged;
    tre_status_type    inj_rec;
    logic              inj_valid;

    always_comb begin
        be_mask     = tre_be_mask(bus.be);
        wr_bits     = bus.wdata & be_mask;
        wr_status   = bus.wr_stb && (bus.addr == OFF_ERROR_RECORD_STATUS);
        wr_inj      = bus.wr_stb && (bus.addr == OFF_ERROR_INJECTION);
        wr_irq_stat = bus.wr_stb && (bus.addr == OFF_IRQ_STATUS);
        wr_irq_mask = bus.wr_stb && (bus.addr == OFF_IRQ_MASK);
        inj_merged  = (r_q.injection & ~be_mask) | wr_bits;
        inj_rec     = tre_status_type'(inj_merged);
    end

    // The check sees the value as it will stand after the byte merge.
    tre_inj_check u_inj_check (
        .rec_i   (inj_rec),
        .valid_o (inj_valid)
    );

    // ------------------------------------------------------------------
    // Hardware error record
    // ------------------------------------------------------------------
    tre_status_type   st_cleared;
    tre_status_type   st_next;
    tre_status_type   st_clr;
    logic             v_clearing;
    logic [IRQ_W-1:0] hw_events;
    logic [IRQ_W-1:0] inj_events;

    always_comb begin
        st_clr     = tre_status_type'(wr_status ? wr_bits : '0);
        v_clearing = st_clr.record_present;
        st_cleared = r_q.status;

        // Clearing the record-present bit empties the whole syndrome so
        // that the next error starts a fresh record.
        if (v_clearing) begin
            st_cleared = tre_status_type'(STATUS_RESET);            // [R10]
        end else begin
            if (st_clr.uncorrected_flag) begin
                st_cleared.uncorrected_flag = 1'b0;
            end
            if (st_clr.overflow_flag) begin
                st_cleared.overflow_flag = 1'b0;
            end
            if (st_clr.postponed_error_flag) begin
                st_cleared.postponed_error_flag = 1'b0;
            end
            if (st_clr.correctable_code != CE_NONE) begin
                st_cleared.correctable_code = CE_NONE;
            end
        end

        // Source, class, type and critical fields are never written
        // directly: only the clear of the whole record touches them.
        st_next = st_cleared;                                   // [R1] [R2] [R3]

        // A new error is applied after the clear, so a clear in the same cycle never loses it.
        if (err_valid_i) begin
            if (r_q.status.record_present && !v_clearing) begin
                st_next.overflow_flag = 1'b1;                       // [R11]
            end else begin
                st_next.record_present       = 1'b1;                // [R10]
                st_next.uncorrected_flag     = err_uncorrected_i;
                st_next.postponed_error_flag = err_postponed_i;
                st_next.correctable_code     =
                    err_corrected_i ? CE_CORRECTED : CE_NONE;
                st_next.uncorrected_type     = UET_UC;
                st_next.critical_flag        = err_critical_i;      // [R1]
                st_next.source_code_field    = err_source_i;        // [R2]
                st_next.error_class_code     = err_class_i;         // [R3]
            end
            if (err_multi_i) begin
                st_next.overflow_flag = 1'b1;                       // [R11]
            end
        end

        // Injection overrides the hardware record in the same cycle.
        if (wr_inj && inj_valid) begin
            st_next = tre_status_type'(inj_merged & STATUS_IMPL);   // [R4]
        end
    end

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    always_comb begin
        hw_events = '0;
        if (err_valid_i) begin
            hw_events[IRQ_RECOVERY] = err_uncorrected_i;
            hw_events[IRQ_FAULT]    = err_postponed_i | err_corrected_i;
            hw_events[IRQ_CRITICAL] = err_critical_i;
        end

        // An injected record raises exactly what a real one of its kind
        // would; an invalid one raises nothing.
        inj_events = '0;
        if (wr_inj && inj_valid) begin                              // [R12]
            inj_events[IRQ_RECOVERY] = inj_rec.uncorrected_flag;    // [R7]
            inj_events[IRQ_FAULT]    = inj_rec.postponed_error_flag |
                (inj_rec.correctable_code == CE_CORRECTED);
            inj_events[IRQ_CRITICAL] = inj_rec.critical_flag;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d        = r_q;
        r_d.status = st_next;

        // The injection register keeps every written bit, valid or not.
        if (wr_inj) begin
            r_d.injection = inj_merged;                             // [R8] [R12]
        end

        if (wr_irq_mask) begin
            r_d.irq_mask = wr_bits[IRQ_W-1:0] |
                (r_q.irq_mask & ~be_mask[IRQ_W-1:0]);
        end

        // Set wins over a write-one-to-clear in the same cycle.
        r_d.irq_stat = r_q.irq_stat;
        if (wr_irq_stat) begin
            r_d.irq_stat = r_q.irq_stat & ~wr_bits[IRQ_W-1:0];
        end
        r_d.irq_stat = r_d.irq_stat | hw_events | inj_events;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_q <= '{injection: INJ_RESET,
                     status:    tre_status_type'(STATUS_RESET),
                     irq_stat:  IRQ_STAT_RESET,
                     irq_mask:  IRQ_MASK_RESET};
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [DISC_DEPTH_W-1:0] depth_field;

    always_comb begin
        depth_field = DISC_DEPTH_W'(MAIN_TLB_DEPTH_PARAM);
        case (bus.addr)
            OFF_MAIN_TLB_DEPTH_DISC:
                bus.rdata = {{(DATA_W-DISC_DEPTH_W){1'b0}},
                             depth_field};                          // [R9]
            OFF_ERROR_RECORD_STATUS:
                bus.rdata = DATA_W'(r_q.status) & STATUS_IMPL;
            OFF_ERROR_INJECTION:
                bus.rdata = r_q.injection;                          // [R8]
            OFF_IRQ_STATUS:
                bus.rdata = {{(DATA_W-IRQ_W){1'b0}}, r_q.irq_stat};
            OFF_IRQ_MASK:
                bus.rdata = {{(DATA_W-IRQ_W){1'b0}}, r_q.irq_mask};
            default:
                bus.rdata = '0;
        endcase
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    assign irq_status_o = r_q.irq_stat;
    assign irq_o        = |(r_q.irq_stat & r_q.irq_mask);

endmodule : tre_ras_regs

// ===== tre_ras_regs_sva.sv
// Concurrent checks for the error record register bank.
// Assumes it is bound to tre_ras_regs and sees only its ports.
`timescale 1ns/1ns
module tre_ras_regs_sva
    import tre_pkg::*;
#(
    parameter int unsigned MAIN_TLB_DEPTH_PARAM = 8
) (
    input wire logic                       clk_sys_i,
    input wire logic                       rstn_i,
    input wire logic [tre_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic                       avs_read_i,
    input wire logic                       avs_write_i,
    input wire logic [tre_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic                       avs_waitrequest_o,
    input wire logic                       err_valid_i,
    input wire logic                       err_uncorrected_i,
    input wire logic                       err_corrected_i,
    input wire logic                       err_critical_i,
    input wire logic [tre_pkg::IRQ_W-1:0]  irq_status_o,
    input wire logic                       irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    sequence s_req_start;
        $rose(avs_read_i | avs_write_i);
    endsequence
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    sequence s_rd_done;
        avs_read_i && !avs_waitrequest_o;
    endsequence

    property p_one_wait;
        s_req_start |-> s_one_wait;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count");
    property p_done_once;
        (avs_read_i | avs_write_i) && !avs_waitrequest_o
            |=> !(avs_read_i | avs_write_i) || avs_waitrequest_o;
    endproperty
    a_done_once: assert property (p_done_once) else $error("repeat done");

    // ------------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------------
    property p_disc;
        s_rd_done ##0 (avs_address_i == OFF_MAIN_TLB_DEPTH_DISC)
            |-> avs_readdata_o == 32'(MAIN_TLB_DEPTH_PARAM);
    endproperty
    a_disc: assert property (p_disc) else $error("depth read");
    // An empty record reads as all zero, so no stale syndrome leaks out.
    property p_empty;
        s_rd_done ##0 (avs_address_i == OFF_ERROR_RECORD_STATUS)
            ##0 !avs_readdata_o[30] |-> avs_readdata_o == 32'h0000_0000;
    endproperty
    a_empty: assert property (p_empty) else $error("empty record");

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    property p_rec_irq;
        err_valid_i && err_uncorrected_i |=> irq_status_o[IRQ_RECOVERY];
    endproperty
    a_rec_irq: assert property (p_rec_irq) else $error("recovery irq");
    property p_flt_irq;
        err_valid_i && err_corrected_i |=> irq_status_o[IRQ_FAULT];
    endproperty
    a_flt_irq: assert property (p_flt_irq) else $error("fault irq");
    property p_crit_irq;
        err_valid_i && err_critical_i |=> irq_status_o[IRQ_CRITICAL];
    endproperty
    a_crit_irq: assert property (p_crit_irq) else $error("crit irq");
    property p_sticky;
        !(avs_write_i && !avs_waitrequest_o)
            |=> (irq_status_o & $past(irq_status_o)) == $past(irq_status_o);
    endproperty
    a_sticky: assert property (p_sticky) else $error("irq not sticky");
    property p_irq_cause;
        irq_o |-> irq_status_o != 3'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("no cause");
endmodule : tre_ras_regs_sva

bind tre_ras_regs tre_ras_regs_sva #(
    .MAIN_TLB_DEPTH_PARAM(MAIN_TLB_DEPTH_PARAM)
) tre_ras_regs_sva_i (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .err_valid_i(err_valid_i), .err_uncorrected_i(err_uncorrected_i),
    .err_corrected_i(err_corrected_i), .err_critical_i(err_critical_i),
    .irq_status_o(irq_status_o), .irq_o(irq_o)
);

// ===== tre_ras_regs_tb.sv
// Self-checking bench for the error record register bank.
// Assumes the design answers every access within twenty cycles.
`timescale 1ns/1ns
module tre_ras_regs_tb;
    import tre_pkg::*;

    logic              clk_sys_i, rstn_i, avs_read_i, avs_write_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [31:0]       avs_writedata_i, avs_readdata_o, q;
    logic [3:0]        avs_byteenable_i;
    logic              avs_waitrequest_o, irq_o, err_valid_i, err_multi_i;
    logic              err_uncorrected_i, err_corrected_i, err_critical_i;
    logic              err_postponed_i;
    logic [7:0]        err_source_i, err_class_i;
    logic [2:0]        irq_status_o;
    int                failures, num_checks;
    localparam logic [31:0] INJ [8] = '{32'h6000_1502, 32'h4080_0008,
        32'h4200_0009, 32'h6100_0000, 32'h4000_0000, 32'h6010_0000,
        32'h2000_0000, 32'h6008_1002};
    localparam logic [2:0] IRQX [8] = '{3'h1, 3'h2, 3'h2, 3'h0, 3'h0,
        3'h0, 3'h0, 3'h5};

    tre_ras_regs #(.MAIN_TLB_DEPTH_PARAM(8)) tre_ras_regs_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .err_valid_i(err_valid_i),
        .err_multi_i(err_multi_i), .err_uncorrected_i(err_uncorrected_i),
        .err_postponed_i(err_postponed_i), .err_corrected_i(err_corrected_i),
        .err_critical_i(err_critical_i), .err_source_i(err_source_i),
        .err_class_i(err_class_i), .irq_status_o(irq_status_o),
        .irq_o(irq_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // The request stands until the rising edge that sees waitrequest low;
    // read data is taken at that edge and the request released after it.
    task automatic bus(logic wr, logic [15:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (n == 20) begin
            failures++;
            conclude();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask : bus

    task automatic rd(string name, logic [15:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(name, exp, q);
    endtask : rd

    task automatic hw_err(logic m, logic ue, logic ce, logic ci,
                          logic [7:0] s, logic [7:0] c);
        @(posedge clk_sys_i);
        err_valid_i       <= 1'b1;
        err_multi_i       <= m;
        err_uncorrected_i <= ue;
        err_corrected_i   <= ce;
        err_critical_i    <= ci;
        err_source_i      <= s;
        err_class_i       <= c;
        @(posedge clk_sys_i);
        err_valid_i <= 1'b0;
        err_multi_i <= 1'b0;
    endtask : hw_err

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {avs_read_i, avs_write_i, err_valid_i, err_multi_i} = 4'h0;
        {err_uncorrected_i, err_corrected_i, err_critical_i} = 3'h0;
        err_postponed_i = 1'b0;
        {avs_address_i, avs_writedata_i} = 48'h0;
        {err_source_i, err_class_i} = 16'h0000;
        avs_byteenable_i = 4'hF;
        failures = 0;
        num_checks = 0;
        rstn_i = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        rd("depth", OFF_MAIN_TLB_DEPTH_DISC, 32'h0000_0008);
        rd("inj_rst", OFF_ERROR_INJECTION, 32'h0000_0000);
        rd("stat_rst", OFF_ERROR_RECORD_STATUS, 32'h0000_0000);
        rd("mask_rst", OFF_IRQ_MASK, 32'h0000_0000);
        rd("unmapped", 16'h1234, 32'h0000_0000);
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0007);
        bus(1'b1, OFF_ERROR_RECORD_STATUS, 32'hFFFF_FFFF);
        rd("st_ro", OFF_ERROR_RECORD_STATUS, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, OFF_ERROR_RECORD_STATUS, 32'h4000_0000);
            bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0007);
            bus(1'b1, OFF_ERROR_INJECTION, INJ[i]);
            rd("inj", OFF_ERROR_INJECTION, INJ[i]);
            rd("inj_stat", OFF_ERROR_RECORD_STATUS,
               (IRQX[i] != 3'h0) ? INJ[i] : 32'h0000_0000);
            check("inj_irq", 32'(IRQX[i]), 32'(irq_status_o));
            check("irq_o", 32'(IRQX[i] != 3'h0), 32'(irq_o));
        end
        // Only the low byte lane lands; the merged record is still valid.
        avs_byteenable_i <= 4'h1;
        bus(1'b1, OFF_ERROR_INJECTION, 32'hFFFF_FF55);
        avs_byteenable_i <= 4'hF;
        rd("inj_be", OFF_ERROR_INJECTION, 32'h6008_1055);
        rd("inj_be_st", OFF_ERROR_RECORD_STATUS, 32'h6008_1055);
        bus(1'b1, OFF_ERROR_RECORD_STATUS, 32'h4000_0000);
        bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0007);
        hw_err(1'b0, 1'b1, 1'b0, 1'b0, 8'h10, CLASS_MAIN_TLB_DATA);
        rd("hw_first", OFF_ERROR_RECORD_STATUS, 32'h6000_1008);
        check("hw_irq", 32'h0000_0001, 32'(irq_status_o));
        // A second error must keep the first syndrome and flag overflow.
        hw_err(1'b0, 1'b0, 1'b1, 1'b0, 8'h0C, CLASS_MAIN_TLB_TAGS);
        rd("hw_ovf", OFF_ERROR_RECORD_STATUS, 32'h6800_1008);
        bus(1'b1, OFF_ERROR_RECORD_STATUS, 32'h0038_FFFF);
        rd("ro", OFF_ERROR_RECORD_STATUS, 32'h6800_1008);
        bus(1'b1, OFF_ERROR_RECORD_STATUS, 32'h4000_0000);
        rd("w1c", OFF_ERROR_RECORD_STATUS, 32'h0000_0000);
        err_postponed_i <= 1'b1;
        hw_err(1'b1, 1'b0, 1'b1, 1'b1, 8'h0C, CLASS_MAIN_TLB_TAGS);
        err_postponed_i <= 1'b0;
        rd("hw_multi", OFF_ERROR_RECORD_STATUS, 32'h4A88_0C09);
        check("multi_irq", 32'h0000_0007, 32'(irq_status_o));
        bus(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
        @(negedge clk_sys_i);
        check("masked", 32'h0000_0000, 32'(irq_o));
        bus(1'b1, OFF_IRQ_STATUS, 32'h0000_0007);
        @(negedge clk_sys_i);
        check("irq_clr", 32'h0000_0000, 32'(irq_status_o));
        conclude();
    end
endmodule : tre_ras_regs_tb
